// *** hw/bfu_pkg.sv ***
package bfu_pkg;

  // Data path and operand widths
  localparam int DATA_W = 8;
  localparam int BIT_W = 3;
  localparam int IO_AW = 5;
  localparam int CNT_W = 8;

  // Status register flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam int MSB = 7;
  localparam int LSB = 0;

  // Software register indexes
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_COUNT = 4'h2;
  localparam logic [3:0] REG_LAST = 4'h3;

  // Control register fields
  localparam int CTRL_SLEEP_EN = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_MODE_HI = 2;
  localparam int CTRL_ERR = 7;

  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BIT = 8'h01;

  // Decoded operation codes handed over by the fetch/decode path
  typedef enum logic [3:0] {
    op_nop = 4'h0,
    io_bit_set_op = 4'h1,
    io_bit_clear_op = 4'h2,
    rotate_left_carry_op = 4'h3,
    rotate_right_carry_op = 4'h4,
    bit_to_transfer_flag_op = 4'h5,
    transfer_flag_to_bit_op = 4'h6,
    overflow_set_op = 4'h7,
    overflow_clear_op = 4'h8,
    signed_flag_set_op = 4'h9,
    signed_flag_clear_op = 4'hA,
    half_carry_set_op = 4'hB,
    half_carry_clear_op = 4'hC,
    sleep_op = 4'hD,
    watchdog_restart_op = 4'hE
  } bfu_op_t;

  // One-hot mask selecting bit b of a byte
  function automatic logic [7:0] bfu_bit_mask(input logic [2:0] b);
    return ONE_BIT << b;
  endfunction

endpackage

// *** hw/bfu_exec_if.sv ***
interface bfu_exec_if;
  import bfu_pkg::*;
  // Flag and register path
  bfu_op_t op;
  logic [7:0] operand;
  logic [2:0] bit_sel;
  logic [7:0] status_register_in;
  logic [7:0] result;
  logic result_we;
  logic [7:0] status_register_val;
  logic [7:0] status_register_mask;
  logic illegal;
  // I/O read-modify-write path
  logic rmw_start;
  logic rmw_set;
  logic [IO_AW-1:0] rmw_addr;
  logic rmw_busy;

  modport core (output op, operand, bit_sel, status_register_in, rmw_start, rmw_set, rmw_addr,
    input result, result_we, status_register_val, status_register_mask, illegal, rmw_busy);
  modport alu (input op, operand, bit_sel, status_register_in,
    output result, result_we, status_register_val, status_register_mask, illegal);
  modport rmw (input bit_sel, rmw_start, rmw_set, rmw_addr, output rmw_busy);
endinterface

// *** hw/bfu_bit_alu.sv ***
module bfu_bit_alu (
  // Operation in, results out
  bfu_exec_if.alu ex
);
  import bfu_pkg::*;

  logic [7:0] rot;
  logic [7:0] msk;

  // Pure combinational; the core registers whatever it keeps
  always_comb begin
    rot = ZERO_BYTE;
    msk = bfu_bit_mask(ex.bit_sel);
    ex.result = ex.operand;
    ex.result_we = 1'b0;
    ex.status_register_val = ex.status_register_in;
    ex.status_register_mask = ZERO_BYTE;
    ex.illegal = 1'b0;
    unique case (ex.op)
      op_nop, io_bit_set_op, io_bit_clear_op, sleep_op, watchdog_restart_op: begin
      end
      rotate_left_carry_op, rotate_right_carry_op: begin
        if (ex.op == rotate_left_carry_op) begin
          rot = {ex.operand[MSB-1:LSB], ex.status_register_in[FLAG_C]};
          ex.status_register_val[FLAG_C] = ex.operand[MSB];
        end else begin
          rot = {ex.status_register_in[FLAG_C], ex.operand[MSB:LSB+1]};
          ex.status_register_val[FLAG_C] = ex.operand[LSB];
        end
        ex.result = rot;
        ex.result_we = 1'b1;
        ex.status_register_val[FLAG_Z] = (rot == ZERO_BYTE);
        ex.status_register_val[FLAG_N] = rot[MSB];
        ex.status_register_val[FLAG_V] = rot[MSB] ^ ex.status_register_val[FLAG_C];
        ex.status_register_mask = bfu_bit_mask(BIT_W'(FLAG_C)) | bfu_bit_mask(BIT_W'(FLAG_Z)) |
          bfu_bit_mask(BIT_W'(FLAG_N)) | bfu_bit_mask(BIT_W'(FLAG_V));
      end
      bit_to_transfer_flag_op: begin
        ex.status_register_val[FLAG_T] = |(ex.operand & msk);
        ex.status_register_mask = bfu_bit_mask(BIT_W'(FLAG_T));
      end
      transfer_flag_to_bit_op: begin
        // Only the selected bit moves; the rest pass through
        ex.result = ex.status_register_in[FLAG_T] ? (ex.operand | msk) : (ex.operand & ~msk);
        ex.result_we = 1'b1;
      end
      overflow_set_op, overflow_clear_op: begin
        ex.status_register_val[FLAG_V] = (ex.op == overflow_set_op);
        ex.status_register_mask = bfu_bit_mask(BIT_W'(FLAG_V));
      end
      signed_flag_set_op, signed_flag_clear_op: begin
        ex.status_register_val[FLAG_S] = (ex.op == signed_flag_set_op);
        ex.status_register_mask = bfu_bit_mask(BIT_W'(FLAG_S));
      end
      half_carry_set_op, half_carry_clear_op: begin
        ex.status_register_val[FLAG_H] = (ex.op == half_carry_set_op);
        ex.status_register_mask = bfu_bit_mask(BIT_W'(FLAG_H));
      end
      default: begin
        ex.illegal = 1'b1;
      end
    endcase
  end

endmodule // bfu_bit_alu

// *** hw/bfu_io_rmw.sv ***
module bfu_io_rmw (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control from the core
  bfu_exec_if.rmw ex,
  // I/O space
  output logic io_rd_en,
  output logic [bfu_pkg::IO_AW-1:0] io_addr,
  input wire logic [7:0] io_rd_data,
  output logic io_wr_en,
  output logic [7:0] io_wr_data
);
  import bfu_pkg::*;

  typedef enum logic [1:0] {
    rmw_idle = 2'b01,
    rmw_read = 2'b10
  } bfu_rmw_t;

  bfu_rmw_t state_ff, nxt_state;
  logic [IO_AW-1:0] addr_ff, nxt_addr;
  logic [7:0] msk_ff, nxt_msk;
  logic set_ff, nxt_set;
  logic wr_ff, nxt_wr;
  logic [7:0] wdat_ff, nxt_wdat;

  // Read in the cycle after acceptance, write back in the one after that
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_msk = msk_ff;
    nxt_set = set_ff;
    nxt_wr = 1'b0;
    nxt_wdat = wdat_ff;
    unique case (state_ff)
      rmw_idle: begin
        if (ex.rmw_start) begin
          nxt_state = rmw_read;
          nxt_addr = ex.rmw_addr;
          nxt_msk = bfu_bit_mask(ex.bit_sel);
          nxt_set = ex.rmw_set;
        end
      end
      rmw_read: begin
        nxt_state = rmw_idle;
        nxt_wr = 1'b1;
        nxt_wdat = set_ff ? (io_rd_data | msk_ff) : (io_rd_data & ~msk_ff);
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= rmw_idle;
      addr_ff <= '0;
      msk_ff <= ZERO_BYTE;
      set_ff <= 1'b0;
      wr_ff <= 1'b0;
      wdat_ff <= ZERO_BYTE;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      msk_ff <= nxt_msk;
      set_ff <= nxt_set;
      wr_ff <= nxt_wr;
      wdat_ff <= nxt_wdat;
    end
  end

  assign ex.rmw_busy = (state_ff == rmw_read);
  assign io_rd_en = (state_ff == rmw_read);
  assign io_addr = addr_ff;
  assign io_wr_en = wr_ff;
  assign io_wr_data = wdat_ff;

endmodule // bfu_io_rmw

// *** hw/bfu_top.sv ***
module bfu_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,

  // Instruction from decode
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [3:0] instr_code,
  input wire logic [bfu_pkg::BIT_W-1:0] instr_bit,
  input wire logic [bfu_pkg::IO_AW-1:0] instr_io_addr,
  input wire logic [bfu_pkg::DATA_W-1:0] instr_reg_data,

  // General register write-back
  output logic reg_wr_en,
  output logic [bfu_pkg::DATA_W-1:0] reg_wr_data,

  // I/O space
  output logic io_rd_en,
  output logic [bfu_pkg::IO_AW-1:0] io_addr,
  input wire logic [bfu_pkg::DATA_W-1:0] io_rd_data,
  output logic io_wr_en,
  output logic [bfu_pkg::DATA_W-1:0] io_wr_data,

  // Status register and system requests
  output logic [bfu_pkg::DATA_W-1:0] status_q,
  output logic sleep_req,
  output logic [1:0] sleep_mode,
  output logic wdt_restart,

  // Software register port
  input wire logic [3:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata
);
  import bfu_pkg::*;

  bfu_exec_if ex ();

  logic accept;
  bfu_op_t op;
  logic is_rmw;

  logic [7:0] status_register_ff, nxt_status_register;
  logic [7:0] status_register_base;

  logic reg_we_ff, nxt_reg_we;
  logic [7:0] reg_dat_ff, nxt_reg_dat;

  logic sleep_ff, nxt_sleep;
  logic wdt_ff, nxt_wdt;

  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [3:0] last_ff, nxt_last;
  logic [7:0] rdat_ff, nxt_rdat;

  // Decoded code; illegal codes flow to the datapath which flags them
  assign op = bfu_op_t'(instr_code);

  // Stall only while the I/O sequencer holds its read slot
  assign instr_ready = ~ex.rmw_busy;

  assign accept = instr_valid & instr_ready;

  // Only the two I/O bit forms go through the read-modify-write path
  assign is_rmw = (op == io_bit_set_op) | (op == io_bit_clear_op);

  // Datapath request; a stall presents a no-op so nothing changes
  always_comb begin
    ex.op = accept ? op : op_nop;
    ex.operand = instr_reg_data;
    ex.bit_sel = instr_bit;
    ex.status_register_in = status_register_ff;
  end

  // Sequencer start for set/clear of an I/O bit
  always_comb begin
    ex.rmw_start = accept & is_rmw;
    ex.rmw_set = (op == io_bit_set_op);
    ex.rmw_addr = instr_io_addr;
  end

  bfu_bit_alu u_alu (
    .ex(ex.alu)
  );

  bfu_io_rmw u_rmw (
    .ref_clk(ref_clk),
    .rst(rst),
    .ex(ex.rmw),
    .io_rd_en(io_rd_en),
    .io_addr(io_addr),
    .io_rd_data(io_rd_data),
    .io_wr_en(io_wr_en),
    .io_wr_data(io_wr_data)
  );

  // Status register: software write first, then the instruction's own
  // flags on top; merging by mask means a software write to another
  // flag in the same cycle is not lost
  always_comb begin
    status_register_base = status_register_ff;
    if (sw_wr && (sw_addr == REG_STATUS)) begin
      status_register_base = sw_wdata;
    end
    nxt_status_register = (status_register_base & ~ex.status_register_mask) | (ex.status_register_val & ex.status_register_mask);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_register_ff <= STATUS_RST;
    end else begin
      status_register_ff <= nxt_status_register;
    end
  end

  // Register write-back lands one cycle after acceptance
  always_comb begin
    nxt_reg_we = ex.result_we;
    nxt_reg_dat = reg_dat_ff;
    if (ex.result_we) begin
      nxt_reg_dat = ex.result;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_we_ff <= 1'b0;
      reg_dat_ff <= ZERO_BYTE;
    end else begin
      reg_we_ff <= nxt_reg_we;
      reg_dat_ff <= nxt_reg_dat;
    end
  end

  // Sleep and watchdog requests: single-cycle pulses, no flag change.
  // Sleep is only handed over while software has enabled it, so a
  // stray sleep instruction cannot stop the core by accident.
  always_comb begin
    nxt_sleep = accept && (op == sleep_op) && ctrl_ff[CTRL_SLEEP_EN];
    nxt_wdt = accept && (op == watchdog_restart_op);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sleep_ff <= 1'b0;
      wdt_ff <= 1'b0;
    end else begin
      sleep_ff <= nxt_sleep;
      wdt_ff <= nxt_wdt;
    end
  end

  // Control register; the error bit is sticky and cleared by writing
  // one, and a new illegal code in the same cycle wins over the clear
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (sw_wr && (sw_addr == REG_CTRL)) begin
      nxt_ctrl[CTRL_MODE_HI:CTRL_SLEEP_EN] = sw_wdata[CTRL_MODE_HI:CTRL_SLEEP_EN];
      if (sw_wdata[CTRL_ERR]) begin
        nxt_ctrl[CTRL_ERR] = 1'b0;
      end
    end
    if (ex.illegal) begin
      nxt_ctrl[CTRL_ERR] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_ff <= CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Accepted-instruction counter and last accepted code.
  // The counter wraps; it is a debug aid, not a cycle count.
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_last = last_ff;
    if (accept) begin
      nxt_cnt = cnt_ff + CNT_W'(1);
      nxt_last = instr_code;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_ff <= '0;
      last_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
      last_ff <= nxt_last;
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_comb begin
    nxt_rdat = ZERO_BYTE;
    if (sw_rd) begin
      unique case (sw_addr)
        REG_STATUS: nxt_rdat = status_register_ff;
        REG_CTRL: nxt_rdat = ctrl_ff;
        REG_COUNT: nxt_rdat = cnt_ff;
        REG_LAST: nxt_rdat = {4'h0, last_ff};
        default: nxt_rdat = ZERO_BYTE; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdat_ff <= ZERO_BYTE;
    end else begin
      rdat_ff <= nxt_rdat;
    end
  end

  // Outputs
  assign reg_wr_en = reg_we_ff;
  assign reg_wr_data = reg_dat_ff;
  assign status_q = status_register_ff;
  assign sleep_req = sleep_ff;
  assign sleep_mode = ctrl_ff[CTRL_MODE_HI:CTRL_MODE_LO];
  assign wdt_restart = wdt_ff;
  assign sw_rdata = rdat_ff;

endmodule // bfu_top

// *** sim/bfu_assertions.sv ***
module bfu_checker (
  // Clock, reset and instruction
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [3:0] instr_code,
  input wire logic [2:0] instr_bit,
  input wire logic [4:0] instr_io_addr,
  input wire logic [7:0] instr_reg_data,
  // Results and software strobe
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic io_rd_en,
  input wire logic [4:0] io_addr,
  input wire logic [7:0] io_rd_data,
  input wire logic io_wr_en,
  input wire logic [7:0] io_wr_data,
  input wire logic [7:0] status_q,
  input wire logic sleep_req,
  input wire logic wdt_restart,
  input wire logic sw_wr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Taken with no software write beside it, which could move any flag
  logic tv;
  logic tk;
  logic [7:0] fm;
  logic sl_tv;
  logic wd_tv;
  assign tv = instr_valid && instr_ready;
  assign sl_tv = tv && instr_code == 4'hD;
  assign wd_tv = tv && instr_code == 4'hE;
  assign tk = tv && !sw_wr;
  assign fm = instr_code < 4'h9 ? 8'h08 : instr_code < 4'hB ? 8'h10 : 8'h20;

  io_rmw_a:
    assert property (tk && (instr_code == 4'h1 || instr_code == 4'h2) |=> io_rd_en
      && !instr_ready && io_addr == $past(instr_io_addr) ##1 io_wr_en && io_wr_data ==
      ($past(instr_code, 2) == 4'h1 ? $past(io_rd_data) | (8'h01 << $past(instr_bit, 2))
      : $past(io_rd_data) & ~(8'h01 << $past(instr_bit, 2)))) else $error("io bit wrong");
  rot_left_a:
    assert property (tk && instr_code == 4'h3 |=> reg_wr_en && reg_wr_data ==
      {$past(instr_reg_data[6:0]), $past(status_q[0])} && status_q[0] ==
      $past(instr_reg_data[7]) && status_q[3] == (status_q[2] ^ status_q[0]))
      else $error("rotate left wrong");
  rot_right_a:
    assert property (tk && instr_code == 4'h4 |=> reg_wr_en && reg_wr_data ==
      {$past(status_q[0]), $past(instr_reg_data[7:1])} && status_q[0] ==
      $past(instr_reg_data[0]) && status_q[1] == (reg_wr_data == 8'h00))
      else $error("rotate right wrong");
  bit_store_a:
    assert property (tk && instr_code == 4'h5 |=> !reg_wr_en && status_q[6] ==
      |($past(instr_reg_data) & (8'h01 << $past(instr_bit))) &&
      (status_q & 8'hBF) == ($past(status_q) & 8'hBF))
      else $error("bit store wrong");
  bit_load_a:
    assert property (tk && instr_code == 4'h6 |=> reg_wr_en && $stable(status_q) &&
      reg_wr_data == (($past(instr_reg_data) & ~(8'h01 << $past(instr_bit)))
      | ({7'h00, $past(status_q[6])} << $past(instr_bit)))) else $error("bit load wrong");
  flag_force_a:
    assert property (tk && instr_code inside {[4'h7:4'hC]} |=> status_q ==
      ($past(instr_code[0]) ? $past(status_q) | $past(fm) : $past(status_q) & ~$past(fm)))
      else $error("flag force wrong");
  sleep_flags_a:
    assert property (tk && instr_code == 4'hD |=> $stable(status_q) && !reg_wr_en)
      else $error("sleep touched state");
  sleep_cause_a:
    assert property (sleep_req |-> $past(sl_tv))
      else $error("stray sleep request");
  wdt_pulse_a:
    assert property (tk && instr_code == 4'hE |=> wdt_restart && $stable(status_q))
      else $error("watchdog restart wrong");
  wdt_cause_a:
    assert property (wdt_restart |-> $past(wd_tv))
      else $error("stray watchdog restart");
endmodule // bfu_checker

bind bfu_top bfu_checker u_chk (.ref_clk, .rst, .instr_valid, .instr_ready, .instr_code,
  .instr_bit, .instr_io_addr, .instr_reg_data, .reg_wr_en, .reg_wr_data, .io_rd_en,
  .io_addr, .io_rd_data, .io_wr_en, .io_wr_data, .status_q, .sleep_req, .wdt_restart,
  .sw_wr);

// *** sim/bfu_io_model.sv ***
module bfu_io_model (
  // Clock
  input wire logic ref_clk,
  // I/O space access
  input wire logic io_rd_en,
  input wire logic [4:0] io_addr,
  output logic [7:0] io_rd_data,
  input wire logic io_wr_en,
  input wire logic [7:0] io_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [32];
  logic [7:0] idle_ff;
  // Seeded contents so that every address holds a different byte
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 8'(i) * 8'h25;
    idle_ff = 8'h5A;
  end
  // Idle bus shows a moving pattern, so a late sample never sees old data
  always @(posedge ref_clk) begin
    idle_ff <= idle_ff + 8'h01;
    if (io_wr_en) mem[io_addr] <= io_wr_data;
  end
  assign io_rd_data = io_rd_en ? mem[io_addr] : idle_ff;
endmodule // bfu_io_model

// *** sim/tb_bit_and_flag_instruction_unit.sv ***
module tb_bit_and_flag_instruction_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import bfu_pkg::*;
  // Row: code, bit, operand, status before, write-back, status after, {we, sleep, wdt}
  typedef struct packed {
    logic [3:0] c;
    logic [2:0] b;
    logic [7:0] d, s, r, e;
    logic [2:0] p;
  } bfu_row_t;
  logic ref_clk, rst, instr_valid, instr_ready, reg_wr_en, io_rd_en, io_wr_en;
  logic sleep_req, wdt_restart, sw_wr, sw_rd;
  logic [3:0] instr_code, sw_addr;
  logic [2:0] instr_bit;
  logic [4:0] instr_io_addr, io_addr;
  logic [7:0] instr_reg_data, reg_wr_data, io_rd_data, io_wr_data, status_q, sw_wdata, sw_rdata;
  logic [1:0] sleep_mode;
  int n_mismatch, comparisons;
  bfu_row_t rows [16];

  bfu_top u_dut (.ref_clk, .rst, .instr_valid, .instr_ready, .instr_code, .instr_bit,
    .instr_io_addr, .instr_reg_data, .reg_wr_en, .reg_wr_data, .io_rd_en, .io_addr,
    .io_rd_data, .io_wr_en, .io_wr_data, .status_q, .sleep_req, .sleep_mode, .wdt_restart,
    .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata);
  bfu_io_model u_io (.ref_clk, .io_rd_en, .io_addr, .io_rd_data, .io_wr_en, .io_wr_data);

  // Free-running core clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard: a run this long has lost a handshake
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Register port: one-cycle strobes, read data only in the next cycle
  task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 chk(sw_rdata, exp);
  endtask
  // One instruction offered for one cycle; returns just after the taking edge
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [7:0] d,
                       input logic [4:0] a);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_code <= c;
    instr_bit <= b;
    instr_reg_data <= d;
    instr_io_addr <= a;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  // Read-modify-write of one I/O bit; the write lands two cycles after the take
  task automatic io_op(input logic [3:0] c, input logic [4:0] a, input logic [2:0] b);
    logic [7:0] old;
    logic [7:0] st;
    old = u_io.mem[a];
    st = status_q;
    issue(c, b, 8'h00, a);
    chk({7'h00, instr_ready}, 8'h00);
    repeat (3) @(posedge ref_clk);
    #1 chk(u_io.mem[a], c == 4'h1 ? old | (8'h01 << b) : old & ~(8'h01 << b));
    chk(status_q, st);
  endtask

  initial begin
    rst = 1'b1;
    {instr_valid, sw_wr, sw_rd} = 3'h0;
    {instr_code, instr_bit, instr_io_addr, instr_reg_data} = 20'h00000;
    {sw_addr, sw_wdata} = 12'h000;
    n_mismatch = 0;
    comparisons = 0;
    rows = '{'{4'h3, 3'h0, 8'h80, 8'h01, 8'h01, 8'h09, 3'h4},
      '{4'h3, 3'h0, 8'h00, 8'h30, 8'h00, 8'h32, 3'h4},
      '{4'h4, 3'h0, 8'h01, 8'h00, 8'h00, 8'h0B, 3'h4},
      '{4'h4, 3'h0, 8'h02, 8'h01, 8'h81, 8'h0C, 3'h4},
      '{4'h5, 3'h7, 8'h80, 8'h00, 8'h00, 8'h40, 3'h0},
      '{4'h5, 3'h0, 8'hFE, 8'hFF, 8'h00, 8'hBF, 3'h0},
      '{4'h6, 3'h7, 8'h00, 8'h40, 8'h80, 8'h40, 3'h4},
      '{4'h6, 3'h0, 8'hFF, 8'hBF, 8'hFE, 8'hBF, 3'h4},
      '{4'h7, 3'h0, 8'h00, 8'h00, 8'h00, 8'h08, 3'h0},
      '{4'h8, 3'h0, 8'h00, 8'hFF, 8'h00, 8'hF7, 3'h0},
      '{4'h9, 3'h0, 8'h00, 8'h00, 8'h00, 8'h10, 3'h0},
      '{4'hA, 3'h0, 8'h00, 8'hFF, 8'h00, 8'hEF, 3'h0},
      '{4'hB, 3'h0, 8'h00, 8'h00, 8'h00, 8'h20, 3'h0},
      '{4'hC, 3'h0, 8'h00, 8'hFF, 8'h00, 8'hDF, 3'h0},
      '{4'hD, 3'h0, 8'h00, 8'h5A, 8'h00, 8'h5A, 3'h2},
      '{4'hE, 3'h0, 8'h00, 8'hA5, 8'h00, 8'hA5, 3'h1}};
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk(status_q, STATUS_RST);
    // Sleep enabled in mode 2, so the sleep row expects a request
    sw_write(REG_CTRL, 8'h05);
    #1 chk({6'h00, sleep_mode}, 8'h02);
    foreach (rows[i]) begin
      sw_write(REG_STATUS, rows[i].s);
      issue(rows[i].c, rows[i].b, rows[i].d, 5'h00);
      chk({5'h00, reg_wr_en, sleep_req, wdt_restart}, {5'h00, rows[i].p});
      chk(status_q, rows[i].e);
      if (rows[i].p[2]) chk(reg_wr_data, rows[i].r);
    end
    // Back-to-back flag forces with valid held high
    sw_write(REG_STATUS, 8'h00);
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_code <= overflow_set_op;
    @(posedge ref_clk);
    instr_code <= half_carry_set_op;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1 chk(status_q, 8'h28);
    // Every bit position, set then clear, each I/O op issued only after the previous write has landed
    for (int i = 0; i < 8; i++) begin
      io_op(4'h1, 5'(i + 3), 3'(i));
      io_op(4'h2, 5'(i * 3), 3'(7 - i));
    end
    // Unknown code raises the sticky flag and is still counted and kept as last code; unmapped reads give zero
    issue(4'hF, 3'h0, 8'h00, 5'h00);
    sw_read(REG_CTRL, 8'h85);
    sw_read(REG_LAST, 8'h0F);
    sw_read(REG_COUNT, 8'h23);
    sw_read(4'h9, 8'h00);
    // Write one clears the sticky flag; with sleep disabled no request goes out
    sw_write(REG_CTRL, 8'h80);
    issue(4'hD, 3'h0, 8'h00, 5'h00);
    chk({7'h00, sleep_req}, 8'h00);
    sw_read(REG_CTRL, 8'h00);
    // Software write beside a flag force: the forced flag wins, the rest take the write
    @(posedge ref_clk);
    sw_wr <= 1'b1;
    sw_addr <= REG_STATUS;
    sw_wdata <= 8'hF7;
    instr_valid <= 1'b1;
    instr_code <= overflow_set_op;
    @(posedge ref_clk);
    {sw_wr, instr_valid} <= 2'b00;
    #1 chk(status_q, 8'hFF);
    // Second reset in mid-run clears the status byte
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1 chk(status_q, STATUS_RST);
    chk({7'h00, instr_ready}, 8'h01);
    tally_and_finish();
  end
endmodule // tb_bit_and_flag_instruction_unit
